/* File: srsx_pkg.sv */
package srsx_pkg;
    localparam int SRSX_DATA_W = 8;
    localparam int SRSX_ADDR_W = 7;
    localparam int SRSX_PC_W = 13;
    localparam logic [SRSX_DATA_W-1:0] SRSX_ACC_RESET = 8'h00;
    localparam logic [SRSX_PC_W-1:0] SRSX_PC_RESET = 13'h0000;
    localparam logic SRSX_DEST_ACC = 1'b0;
    localparam logic SRSX_DEST_REG = 1'b1;

    // Operation select from the decoder
    typedef enum logic [2:0] {
        SRSX_OP_NONE = 3'h0,
        SRSX_OP_RETURN = 3'h1,
        SRSX_OP_LITERAL_MINUS_ACC = 3'h2,
        SRSX_OP_ROTATE_RIGHT_THRU_CARRY = 3'h3,
        SRSX_OP_OPERAND_MINUS_ACC = 3'h4,
        SRSX_OP_NIBBLE_EXCHANGE = 3'h5,
        SRSX_OP_ACC_XOR_OPERAND = 3'h6,
        SRSX_OP_ACC_XOR_LITERAL = 3'h7
    } srsx_op_type;

    // Sequencer states, Gray along idle -> return
    typedef enum logic [1:0] {
        SRSX_ST_IDLE = 2'b00,
        SRSX_ST_RET2 = 2'b01
    } srsx_state_type;
endpackage : srsx_pkg

/* File: srsx_alu.sv */
`timescale 1ns/10ps
module srsx_alu
    import srsx_pkg::*;
(
    input wire srsx_op_type op,
    input wire logic [SRSX_DATA_W-1:0] acc,
    input wire logic [SRSX_DATA_W-1:0] operand,
    input wire logic [SRSX_DATA_W-1:0] literal,
    input wire logic carry_in,
    output logic [SRSX_DATA_W-1:0] result,
    output logic carry_out,
    output logic half_borrow_out,
    output logic carry_we,
    output logic half_borrow_we,
    output logic zero_we
);
    // Subtract as a + ~b + 1 so carry reads as not-borrow
    function automatic logic [SRSX_DATA_W:0] srsx_sub(input logic [SRSX_DATA_W-1:0] a,
                                                       input logic [SRSX_DATA_W-1:0] b);
        srsx_sub = {1'b0, a} + {1'b0, ~b} + 9'h001;
    endfunction : srsx_sub

    function automatic logic srsx_nib_nb(input logic [SRSX_DATA_W-1:0] a,
                                         input logic [SRSX_DATA_W-1:0] b);
        logic [4:0] s;
        s = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        srsx_nib_nb = s[4];
    endfunction : srsx_nib_nb

    // Result and flag enables per operation
    always_comb begin
        logic [SRSX_DATA_W:0] diff;
        diff = '0;
        result = acc;
        carry_out = carry_in;
        half_borrow_out = 1'b0;
        carry_we = 1'b0;
        half_borrow_we = 1'b0;
        zero_we = 1'b0;
        case (op)
            SRSX_OP_LITERAL_MINUS_ACC: begin
                diff = srsx_sub(literal, acc);
                result = diff[SRSX_DATA_W-1:0];
                carry_out = diff[SRSX_DATA_W];
                half_borrow_out = srsx_nib_nb(literal, acc);
                carry_we = 1'b1;
                half_borrow_we = 1'b1;
                zero_we = 1'b1;
            end
            SRSX_OP_OPERAND_MINUS_ACC: begin
                diff = srsx_sub(operand, acc);
                result = diff[SRSX_DATA_W-1:0];
                carry_out = diff[SRSX_DATA_W];
                half_borrow_out = srsx_nib_nb(operand, acc);
                carry_we = 1'b1;
                half_borrow_we = 1'b1;
                zero_we = 1'b1;
            end
            SRSX_OP_ROTATE_RIGHT_THRU_CARRY: begin
                result = {carry_in, operand[SRSX_DATA_W-1:1]};
                carry_out = operand[0];
                carry_we = 1'b1;
            end
            SRSX_OP_NIBBLE_EXCHANGE: begin
                result = {operand[3:0], operand[7:4]};
            end
            SRSX_OP_ACC_XOR_OPERAND: begin
                result = acc ^ operand;
                zero_we = 1'b1;
            end
            SRSX_OP_ACC_XOR_LITERAL: begin
                result = acc ^ literal;
                zero_we = 1'b1;
            end
            default: begin
                result = acc;
            end
        endcase
    end
endmodule : srsx_alu

/* File: srsx_exec.sv */
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module srsx_exec
    import srsx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic issue,
    input wire srsx_op_type op,
    input wire logic [SRSX_DATA_W-1:0] literal,
    input wire logic [SRSX_ADDR_W-1:0] reg_addr,
    input wire logic dest_sel,
    input wire logic [SRSX_DATA_W-1:0] operand,
    input wire logic [SRSX_PC_W-1:0] stack_top,
    output logic busy,
    output logic done,
    output logic [SRSX_DATA_W-1:0] acc,
    output logic carry,
    output logic half_borrow_bit,
    output logic zero,
    output logic reg_we,
    output logic [SRSX_ADDR_W-1:0] reg_waddr,
    output logic [SRSX_DATA_W-1:0] reg_wdata,
    output logic stack_pop,
    output logic pc_load,
    output logic [SRSX_PC_W-1:0] pc_value
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        srsx_state_type st;
        logic busy;
        logic done;
        logic [SRSX_DATA_W-1:0] acc;
        logic carry;
        logic half_borrow;
        logic zero;
        logic reg_we;
        logic [SRSX_ADDR_W-1:0] reg_waddr;
        logic [SRSX_DATA_W-1:0] reg_wdata;
        logic stack_pop;
        logic pc_load;
        logic [SRSX_PC_W-1:0] pc_value;
    } srsx_regs_type;

    srsx_regs_type r_q;
    srsx_regs_type r_d;
    logic [SRSX_DATA_W-1:0] alu_result;
    logic alu_carry;
    logic alu_half_borrow;
    logic carry_we;
    logic half_borrow_we;
    logic zero_we;
    logic take;

    // Ops are ignored while the return's second cycle runs
    assign take = issue && (r_q.st == SRSX_ST_IDLE);

    srsx_alu u_alu (
        .op(op),
        .acc(r_q.acc),
        .operand(operand),
        .literal(literal),
        .carry_in(r_q.carry),
        .result(alu_result),
        .carry_out(alu_carry),
        .half_borrow_out(alu_half_borrow),
        .carry_we(carry_we),
        .half_borrow_we(half_borrow_we),
        .zero_we(zero_we)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        r_d.reg_we = 1'b0;
        r_d.stack_pop = 1'b0;
        r_d.pc_load = 1'b0;
        case (r_q.st)
            SRSX_ST_IDLE: begin
                if (take) begin
                    case (op)
                        SRSX_OP_RETURN: begin
                            // Pop now, load the PC; flags untouched
                            r_d.stack_pop = 1'b1;
                            r_d.pc_load = 1'b1;
                            r_d.pc_value = stack_top;
                            r_d.st = SRSX_ST_RET2;
                            r_d.busy = 1'b1;
                        end
                        SRSX_OP_NONE: begin
                            r_d.done = 1'b0;
                        end
                        default: begin
                            r_d.done = 1'b1;
                            if (carry_we) begin
                                r_d.carry = alu_carry;
                            end
                            if (half_borrow_we) begin
                                r_d.half_borrow = alu_half_borrow;
                            end
                            if (zero_we) begin
                                r_d.zero = (alu_result == 8'h00);
                            end
                            // Literal forms always land in the accumulator
                            if (op == SRSX_OP_LITERAL_MINUS_ACC || op == SRSX_OP_ACC_XOR_LITERAL
                                || dest_sel == SRSX_DEST_ACC) begin
                                r_d.acc = alu_result;
                            end else begin
                                r_d.reg_we = 1'b1;
                                r_d.reg_waddr = reg_addr;
                                r_d.reg_wdata = alu_result;
                            end
                        end
                    endcase
                end
            end
            SRSX_ST_RET2: begin
                // Second cycle of the return is a flush
                r_d.st = SRSX_ST_IDLE;
                r_d.busy = 1'b0;
                r_d.done = 1'b1;
            end
            default: begin
                r_d.st = SRSX_ST_IDLE;
                r_d.busy = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r_q <= '{st: SRSX_ST_IDLE, busy: 1'b0, done: 1'b0, acc: SRSX_ACC_RESET,
                     carry: 1'b0, half_borrow: 1'b0, zero: 1'b0, reg_we: 1'b0,
                     reg_waddr: '0, reg_wdata: '0, stack_pop: 1'b0, pc_load: 1'b0,
                     pc_value: SRSX_PC_RESET};
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs straight from the state flops
    assign busy = r_q.busy;
    assign done = r_q.done;
    assign acc = r_q.acc;
    assign carry = r_q.carry;
    assign half_borrow_bit = r_q.half_borrow;
    assign zero = r_q.zero;
    assign reg_we = r_q.reg_we;
    assign reg_waddr = r_q.reg_waddr;
    assign reg_wdata = r_q.reg_wdata;
    assign stack_pop = r_q.stack_pop;
    assign pc_load = r_q.pc_load;
    assign pc_value = r_q.pc_value;
endmodule : srsx_exec

/* File: srsx_exec_asserts.sv */
`timescale 1ns/10ps
module srsx_exec_asserts
    import srsx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic issue,
    input wire srsx_op_type op,
    input wire logic [SRSX_DATA_W-1:0] literal,
    input wire logic [SRSX_ADDR_W-1:0] reg_addr,
    input wire logic dest_sel,
    input wire logic [SRSX_DATA_W-1:0] operand,
    input wire logic [SRSX_PC_W-1:0] stack_top,
    input wire logic busy,
    input wire logic done,
    input wire logic [SRSX_DATA_W-1:0] acc,
    input wire logic carry,
    input wire logic half_borrow_bit,
    input wire logic zero,
    input wire logic reg_we,
    input wire logic [SRSX_ADDR_W-1:0] reg_waddr,
    input wire logic [SRSX_DATA_W-1:0] reg_wdata,
    input wire logic stack_pop,
    input wire logic pc_load,
    input wire logic [SRSX_PC_W-1:0] pc_value
);
    // ********
    // Checks
    // ********
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic take;
    logic ret;
    // Issue while busy is dropped, so only idle issues count
    assign take = issue && !busy;
    assign ret = take && op == SRSX_OP_RETURN;
    chk_ret_load: assert property (ret |=> stack_pop && pc_load && busy
        && pc_value == $past(stack_top)) else $error("return load wrong");
    chk_ret_two: assert property (ret |=> !done ##1 done && !busy)
        else $error("return length wrong");
    chk_ret_flags: assert property (ret |=> $stable({acc, carry, half_borrow_bit, zero})[*2])
        else $error("return touched state");
    chk_one_cyc: assert property (take && op > SRSX_OP_RETURN |=> done && !busy)
        else $error("single cycle op late");
    chk_lit_sub: assert property (take && op == SRSX_OP_LITERAL_MINUS_ACC |=>
        acc == $past(literal) - $past(acc) && carry == ($past(literal) >= $past(acc)))
        else $error("literal subtract wrong");
    chk_rot_carry: assert property (take && op == SRSX_OP_ROTATE_RIGHT_THRU_CARRY |=>
        carry == $past(operand[0]) && $stable({half_borrow_bit, zero}))
        else $error("rotate carry wrong");
    chk_swap_keep: assert property (take && op == SRSX_OP_NIBBLE_EXCHANGE |=>
        $stable({carry, half_borrow_bit, zero})) else $error("swap moved a flag");
    chk_xor_keep: assert property (take && op >= SRSX_OP_ACC_XOR_OPERAND |=>
        $stable({carry, half_borrow_bit})) else $error("xor moved carry");
    chk_dest_reg: assert property (take && dest_sel && op inside {[3:6]} |=>
        reg_we && reg_waddr == $past(reg_addr) && $stable(acc))
        else $error("register routing wrong");
    chk_sub_reg: assert property (take && dest_sel && op == SRSX_OP_OPERAND_MINUS_ACC |=>
        reg_wdata == $past(operand) - $past(acc)
        && half_borrow_bit == ($past(operand[3:0]) >= $past(acc[3:0])))
        else $error("register subtract wrong");
    cover property (ret ##2 done);
    cover property (take && op == SRSX_OP_OPERAND_MINUS_ACC && dest_sel);
    cover property (take && op == SRSX_OP_ROTATE_RIGHT_THRU_CARRY);
endmodule : srsx_exec_asserts
bind srsx_exec srsx_exec_asserts u_chk (.clk, .rst_b, .issue, .op, .literal, .reg_addr,
    .dest_sel, .operand, .stack_top, .busy, .done, .acc, .carry, .half_borrow_bit, .zero,
    .reg_we, .reg_waddr, .reg_wdata, .stack_pop, .pc_load, .pc_value);

/* File: srsx_regfile_model.sv */
`timescale 1ns/10ps
module srsx_regfile_model
    import srsx_pkg::*;
(
    input wire logic clk,
    input wire logic [SRSX_ADDR_W-1:0] reg_addr,
    input wire logic reg_we,
    input wire logic [SRSX_ADDR_W-1:0] reg_waddr,
    input wire logic [SRSX_DATA_W-1:0] reg_wdata,
    output logic [SRSX_DATA_W-1:0] operand
);
    logic [SRSX_DATA_W-1:0] mem_q [128];
    // Fixed fill, the bench mirrors it
    initial for (int i = 0; i < 128; i++) mem_q[i] = 8'(i) ^ 8'hA5;
    // Read is combinational, so a write lands only at the next edge
    assign operand = mem_q[reg_addr];
    always @(posedge clk) if (reg_we) mem_q[reg_waddr] <= reg_wdata;
endmodule : srsx_regfile_model

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
    import srsx_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic issue = 1'b0;
    srsx_op_type op = SRSX_OP_NONE;
    logic [7:0] literal = 8'h00;
    logic [6:0] reg_addr = 7'h00;
    logic dest_sel = 1'b0;
    logic [12:0] stack_top = 13'h0000;
    logic [7:0] operand, acc, reg_wdata, e_a = 8'h00;
    logic [7:0] sh [128];
    logic [6:0] reg_waddr;
    logic [12:0] pc_value;
    logic busy, done, carry, half_borrow_bit, zero, reg_we, stack_pop, pc_load;
    logic e_c = 1'b0, e_h = 1'b0, e_z = 1'b0;
    int error_cnt = 0;
    int cmp_count = 0;
    always #10 clk = ~clk;
    srsx_exec u_dut (.clk, .rst_b, .issue, .op, .literal, .reg_addr, .dest_sel, .operand,
        .stack_top, .busy, .done, .acc, .carry, .half_borrow_bit, .zero, .reg_we,
        .reg_waddr, .reg_wdata, .stack_pop, .pc_load, .pc_value);
    srsx_regfile_model u_rf (.clk, .reg_addr, .reg_we, .reg_waddr, .reg_wdata, .operand);
    // ********
    // Tasks
    // ********
    // Wide enough for the 26-bit reset snapshot of acc, flags, busy, done and pc_value
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    // One op, expectations from the bench's own shadow state
    task automatic exec(input srsx_op_type o, input logic [7:0] k, input logic [6:0] a,
        input logic d);
        logic [7:0] f, r, m;
        logic w;
        f = sh[a];
        m = (o == SRSX_OP_LITERAL_MINUS_ACC) ? k : f;
        w = d && o != SRSX_OP_LITERAL_MINUS_ACC && o != SRSX_OP_ACC_XOR_LITERAL;
        case (o)
            SRSX_OP_ROTATE_RIGHT_THRU_CARRY: r = {e_c, f[7:1]};
            SRSX_OP_NIBBLE_EXCHANGE: r = {f[3:0], f[7:4]};
            SRSX_OP_ACC_XOR_OPERAND: r = f ^ e_a;
            SRSX_OP_ACC_XOR_LITERAL: r = k ^ e_a;
            default: r = m - e_a;
        endcase
        @(posedge clk);
        issue <= 1'b1;
        op <= o;
        literal <= k;
        reg_addr <= a;
        dest_sel <= d;
        @(posedge clk);
        issue <= 1'b0;
        #1;
        if (o == SRSX_OP_ROTATE_RIGHT_THRU_CARRY) e_c = f[0];
        if (o inside {[2:2], [4:4]}) begin
            e_c = m >= e_a;
            e_h = m[3:0] >= e_a[3:0];
        end
        if (o inside {[2:2], [4:4], [6:7]}) e_z = r == 8'h00;
        if (w) sh[a] = r;
        else e_a = r;
        cmp({acc, carry, half_borrow_bit, zero, done, reg_we}, {e_a, e_c, e_h, e_z, 1'b1, w});
        if (w) cmp({reg_waddr, reg_wdata}, {a, r});
    endtask : exec
    // Return, with an issue held into the busy cycle that must be dropped
    task automatic ret(input logic [12:0] p);
        @(posedge clk);
        issue <= 1'b1;
        op <= SRSX_OP_RETURN;
        stack_top <= p;
        @(posedge clk);
        op <= SRSX_OP_ACC_XOR_LITERAL;
        literal <= 8'hFF;
        #1;
        cmp({stack_pop, pc_load, busy, pc_value}, {3'b111, p});
        @(posedge clk);
        issue <= 1'b0;
        #1;
        cmp({done, busy, stack_pop, pc_load, acc, carry, half_borrow_bit, zero}, {4'b1000, e_a, e_c, e_h, e_z});
    endtask : ret
    task automatic wrap_up();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // Main sequence: every op code but SRSX_OP_NONE, both destinations, borrow edges, returns
    initial begin
        for (int i = 0; i < 128; i++) sh[i] = 8'(i) ^ 8'hA5;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        cmp({acc, carry, half_borrow_bit, zero, busy, done, pc_value}, 16'h0000);
        for (int i = 0; i < 24; i++) exec(srsx_op_type'(3'(2 + i % 6)), 8'(i * 53), 7'(i * 5), i[3]);
        exec(SRSX_OP_ACC_XOR_LITERAL, e_a, 7'h00, 1'b0);
        exec(SRSX_OP_LITERAL_MINUS_ACC, 8'h01, 7'h00, 1'b0);
        exec(SRSX_OP_LITERAL_MINUS_ACC, 8'h00, 7'h00, 1'b0);
        exec(SRSX_OP_LITERAL_MINUS_ACC, 8'hFF, 7'h7F, 1'b1);
        ret(13'h1ABC);
        ret(13'h0005);
        // Mid-run reset: state clears, register file keeps its contents
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        cmp({acc, carry, half_borrow_bit, zero, busy, done, pc_value}, 32'h00000000);
        {e_a, e_c, e_h, e_z} = 11'h000;
        exec(SRSX_OP_ROTATE_RIGHT_THRU_CARRY, 8'h00, 7'h7F, 1'b0);
        wrap_up();
    end
    // Watchdog well past the roughly 72 cycles the tests need
    initial begin
        #40000;
        error_cnt++;
        wrap_up();
    end
endmodule : tb
